// ==== logic/rmh_defs.svh ====
`ifndef RMH_DEFS_SVH
`define RMH_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RMH_OFS_CTRL 12'h000
`define RMH_OFS_STAT 12'h004
`define RMH_OFS_ESR 12'h008
`define RMH_OFS_ERRQ 12'h00C
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define RMH_CTRL_MODE_LSB 0
`define RMH_CTRL_TRGBUS_BIT 2
`define RMH_CTRL_RST 3'h0
`define RMH_ESR_OPC_BIT 0
`define RMH_ESR_QYE_BIT 2
`define RMH_ESR_RST 8'h00
`define RMH_STB_MAV_BIT 4
// ----------------------------------------
// sizes and codes
// ----------------------------------------
`define RMH_IN_DEPTH 1024
`define RMH_OUT_DEPTH 65536
`define RMH_ERR_DEPTH 16
`define RMH_BYTE_LF 8'h0A
`define RMH_BYTE_ONE 8'h31
`define RMH_ERR_QOVF 8'hFF
`endif

// ==== logic/rmh_pkg.sv ====
package rmh_pkg;
	typedef enum logic [1:0]
	{
		RMH_LINK_BUS = 2'b00,
		RMH_LINK_USB = 2'b01,
		RMH_LINK_SER = 2'b10
	} rmh_link_t;
	typedef enum logic [1:0]
	{
		RMH_TX_DATA = 2'b00,
		RMH_TX_LF = 2'b01
	} rmh_tx_t;
	typedef struct packed
	{
		logic ren;
		logic listen;
		logic unlisten;
		logic talk;
		logic untalk;
		logic ifc;
		logic dcl;
		logic llo;
		logic gtl;
		logic get;
		logic usb_detach;
	} rmh_ifmsg_t;
	typedef struct packed
	{
		logic valid;
		logic [7:0] data;
		logic last;
	} rmh_resp_t;
endpackage : rmh_pkg

// ==== logic/rmh_handler.sv ====
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "rmh_defs.svh"
// How it works
// RULE1: received bytes go through a 1024-byte buffer, strictly in order, with back-pressure.
// RULE2: a reported error drops further command bytes up to the next terminator.
// RULE3: pending response bytes wait in a 65536-byte output buffer.
// RULE4: a response byte into a full output buffer flushes it and sets query error.
// RULE5: after an overflow, responses are discarded until the next terminator is consumed.
// RULE6: the error queue holds at most sixteen entries.
// RULE7: on overflow keep fifteen, sixteenth becomes queue-overflow, later errors dropped.
// RULE8: the controller ends each command string with line feed, plus end on bus.
// RULE9: on the serial link a line feed alone terminates a message.
// RULE10: local state passes panel keys; remote passes only the return-to-local key.
// RULE11: on bus, remote enable true while listener-addressed enters remote.
// RULE12: the return-to-local key leaves remote unless lockout is active.
// RULE13: go-to-local, remote enable falling or usb detach return to local.
// RULE14: under lockout the key is ignored but the controller can still restore local.
// RULE15: on serial, any received byte sets remote; only the key restores local.
// RULE16: the remote lamp is lit whenever the device is remote.
// RULE17: interface clear reinitialises the interface and drops talk and listen addressing.
// RULE18: device clear flushes both buffers, aborts parsing, clears MAV, releases waits.
// RULE19: local lockout blocks the key-driven remote to local transition.
// RULE20: group execute trigger acts exactly like the trigger command.
// RULE21: opc sets the esr opc bit, opc query answers 1, once operations finish.
// RULE22: a trigger starts one measurement only with bus source while awaiting trigger.
// RULE23: on bus, line feed, line feed with end, or end on any byte terminate.
// RULE24: on bus every response ends with a line feed carrying the end indication.
// RULE25: MAV is high while the output buffer holds at least one unread byte.
module rmh_handler (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_end,
	output logic rx_ready,
	output logic cmd_valid,
	output logic [7:0] cmd_data,
	output logic cmd_term,
	input wire logic cmd_ready,
	input wire logic exe_error,
	input wire logic [7:0] exe_error_code,
	input wire rmh_pkg::rmh_resp_t resp,
	input wire logic opc_cmd,
	input wire logic opc_query,
	input wire logic trg_cmd,
	input wire logic ops_busy,
	input wire logic trig_waiting,
	input wire logic meas_done,
	output logic meas_start,
	output logic data_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_end,
	input wire logic tx_ready,
	input wire rmh_pkg::rmh_ifmsg_t ifmsg,
	input wire logic panel_key,
	input wire logic panel_local_key,
	output logic panel_key_pass,
	output logic remote_lamp,
	output logic listener,
	output logic talker,
	output logic ifc_reinit,
	output logic parse_abort,
	output logic wait_release,
	output logic [7:0] stb_mav
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic is_term(input logic [7:0] b, input logic e, input rmh_pkg::rmh_link_t m);
		is_term = (b == `RMH_BYTE_LF) || (e && m != rmh_pkg::RMH_LINK_SER);
	endfunction : is_term

	logic [2:0] ctrl_reg;
	logic [7:0] esr_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	rmh_pkg::rmh_link_t mode;
	assign mode = rmh_pkg::rmh_link_t'(ctrl_reg[`RMH_CTRL_MODE_LSB +: 2]);

	// ----------------------------------------
	// panel key synchroniser
	// ----------------------------------------
	logic [1:0] key_sync_reg;
	logic [1:0] lkey_sync_reg;
	logic lkey_d_reg;
	logic lkey_press;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			key_sync_reg <= 2'h0;
			lkey_sync_reg <= 2'h0;
			lkey_d_reg <= 1'b0;
		end
		else
		begin
			key_sync_reg <= {key_sync_reg[0], panel_key};
			lkey_sync_reg <= {lkey_sync_reg[0], panel_local_key};
			lkey_d_reg <= lkey_sync_reg[1];
		end
	end
	assign lkey_press = lkey_sync_reg[1] & ~lkey_d_reg;

	// ----------------------------------------
	// remote / local state
	// ----------------------------------------
	logic remote_reg;
	logic llo_reg;
	logic ren_d_reg;
	logic lstn_reg;
	logic talk_reg;
	logic to_local;
	logic rx_fire;
	assign rx_fire = rx_valid & rx_ready;
	always_comb
	begin
		to_local = lkey_press & ~llo_reg; // RULE12 RULE14 RULE19
		if (mode != rmh_pkg::RMH_LINK_SER)
			to_local = to_local | ifmsg.gtl | (ren_d_reg & ~ifmsg.ren)
				| (ifmsg.usb_detach & (mode == rmh_pkg::RMH_LINK_USB)); // RULE13 RULE14
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			remote_reg <= 1'b0;
			llo_reg <= 1'b0;
			ren_d_reg <= 1'b0;
		end
		else
		begin
			ren_d_reg <= ifmsg.ren;
			if (mode == rmh_pkg::RMH_LINK_SER)
				llo_reg <= 1'b0; // RULE15
			else if (!ifmsg.ren)
				llo_reg <= 1'b0;
			else if (ifmsg.llo)
				llo_reg <= 1'b1; // RULE19
			if (to_local)
				remote_reg <= 1'b0; // RULE10
			else if (mode == rmh_pkg::RMH_LINK_SER && rx_fire)
				remote_reg <= 1'b1; // RULE15
			else if (mode != rmh_pkg::RMH_LINK_SER && ifmsg.ren && lstn_reg)
				remote_reg <= 1'b1; // RULE11
		end
	end
	assign remote_lamp = remote_reg; // RULE16
	assign panel_key_pass = key_sync_reg[1] & ~remote_reg; // RULE10

	// ----------------------------------------
	// addressing and interface clear
	// ----------------------------------------
	logic ifc_reg;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lstn_reg <= 1'b0;
			talk_reg <= 1'b0;
			ifc_reg <= 1'b0;
		end
		else
		begin
			ifc_reg <= ifmsg.ifc;
			if (ifmsg.ifc || ifmsg.unlisten)
				lstn_reg <= 1'b0; // RULE17
			else if (ifmsg.listen)
				lstn_reg <= 1'b1;
			if (ifmsg.ifc || ifmsg.untalk || ifmsg.listen)
				talk_reg <= 1'b0; // RULE17
			else if (ifmsg.talk)
				talk_reg <= 1'b1;
		end
	end
	assign listener = lstn_reg;
	assign talker = talk_reg;
	assign ifc_reinit = ifc_reg;

	// ----------------------------------------
	// input buffer and parser feed
	// ----------------------------------------
	logic [8:0] in_mem [`RMH_IN_DEPTH];
	logic [9:0] in_wp_reg;
	logic [9:0] in_rp_reg;
	logic [10:0] in_cnt_reg;
	logic dcl;
	logic in_pop;
	logic [8:0] in_head;
	logic head_term;
	logic skip_reg;
	logic cmd_valid_reg;
	logic [7:0] cmd_data_reg;
	logic cmd_term_reg;
	logic stage_free;
	assign dcl = ifmsg.dcl & (mode != rmh_pkg::RMH_LINK_SER);
	assign rx_ready = (in_cnt_reg != 11'(`RMH_IN_DEPTH)) & ~dcl; // RULE1
	assign in_head = in_mem[in_rp_reg];
	assign head_term = is_term(in_head[7:0], in_head[8], mode); // RULE9 RULE23
	assign stage_free = ~cmd_valid_reg | cmd_ready;
	assign in_pop = (in_cnt_reg != 11'h000) & stage_free & ~dcl;
	always_ff @(posedge pclk)
	begin
		if (rx_fire)
			in_mem[in_wp_reg] <= {rx_end, rx_data};
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			in_wp_reg <= 10'h000;
			in_rp_reg <= 10'h000;
			in_cnt_reg <= 11'h000;
		end
		else if (dcl)
		begin
			in_wp_reg <= 10'h000; // RULE18
			in_rp_reg <= 10'h000;
			in_cnt_reg <= 11'h000;
		end
		else
		begin
			if (rx_fire)
				in_wp_reg <= in_wp_reg + 10'h001;
			if (in_pop)
				in_rp_reg <= in_rp_reg + 10'h001;
			in_cnt_reg <= in_cnt_reg + 11'(rx_fire) - 11'(in_pop); // RULE1
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_valid_reg <= 1'b0;
			cmd_data_reg <= 8'h00;
			cmd_term_reg <= 1'b0;
		end
		else if (dcl)
			cmd_valid_reg <= 1'b0; // RULE18
		else if (stage_free)
		begin
			cmd_valid_reg <= in_pop & (~skip_reg | head_term); // RULE2
			cmd_data_reg <= in_head[7:0];
			cmd_term_reg <= head_term;
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			skip_reg <= 1'b0;
		else if (exe_error)
			skip_reg <= 1'b1; // RULE2
		else if (dcl || (in_pop && head_term))
			skip_reg <= 1'b0;
	end
	assign cmd_valid = cmd_valid_reg;
	assign cmd_data = cmd_data_reg;
	assign cmd_term = cmd_term_reg;

	// ----------------------------------------
	// output buffer
	// ----------------------------------------
	logic [8:0] out_mem [`RMH_OUT_DEPTH];
	logic [15:0] out_wp_reg;
	logic [15:0] out_rp_reg;
	logic [16:0] out_cnt_reg;
	logic drop_reg;
	logic opc_q_reg;
	logic opc_q_fire;
	logic push_req;
	logic [8:0] push_word;
	logic out_push;
	logic out_ovf;
	logic out_pop;
	logic term_taken;
	rmh_pkg::rmh_tx_t tx_st_reg;
	logic tx_valid_reg;
	logic [7:0] tx_data_reg;
	logic tx_end_reg;
	logic tx_load;
	assign term_taken = cmd_valid_reg & cmd_ready & cmd_term_reg;
	assign opc_q_fire = opc_q_reg & ~ops_busy & ~resp.valid;
	assign push_req = resp.valid | opc_q_fire;
	assign push_word = resp.valid ? {resp.last, resp.data} : {1'b1, `RMH_BYTE_ONE}; // RULE21
	assign out_ovf = push_req & ~drop_reg & (out_cnt_reg == 17'(`RMH_OUT_DEPTH)); // RULE4
	assign out_push = push_req & ~drop_reg & ~out_ovf & ~dcl; // RULE5
	assign tx_load = ~tx_valid_reg | tx_ready;
	assign out_pop = tx_load & (tx_st_reg == rmh_pkg::RMH_TX_DATA) & (out_cnt_reg != 17'h00000) & ~dcl;
	always_ff @(posedge pclk)
	begin
		if (out_push)
			out_mem[out_wp_reg] <= push_word; // RULE3
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_wp_reg <= 16'h0000;
			out_rp_reg <= 16'h0000;
			out_cnt_reg <= 17'h00000;
		end
		else if (dcl || out_ovf)
		begin
			out_wp_reg <= 16'h0000; // RULE4 RULE18
			out_rp_reg <= 16'h0000;
			out_cnt_reg <= 17'h00000;
		end
		else
		begin
			if (out_push)
				out_wp_reg <= out_wp_reg + 16'h0001;
			if (out_pop)
				out_rp_reg <= out_rp_reg + 16'h0001;
			out_cnt_reg <= out_cnt_reg + 17'(out_push) - 17'(out_pop);
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			drop_reg <= 1'b0;
		else if (out_ovf)
			drop_reg <= 1'b1; // RULE5
		else if (dcl || term_taken)
			drop_reg <= 1'b0;
	end
	// a byte parked in the tx stage is still unread by the host
	assign stb_mav = {3'h0, (out_cnt_reg != 17'h0_0000) | tx_valid_reg, 4'h0}; // RULE25 RULE18

	// ----------------------------------------
	// response transmitter
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_st_reg <= rmh_pkg::RMH_TX_DATA;
			tx_valid_reg <= 1'b0;
			tx_data_reg <= 8'h00;
			tx_end_reg <= 1'b0;
		end
		else if (dcl)
		begin
			tx_st_reg <= rmh_pkg::RMH_TX_DATA;
			tx_valid_reg <= 1'b0;
		end
		else if (tx_load)
		begin
			case (tx_st_reg)
				rmh_pkg::RMH_TX_DATA:
				begin
					tx_valid_reg <= out_pop;
					tx_data_reg <= out_mem[out_rp_reg][7:0];
					tx_end_reg <= 1'b0;
					if (out_pop && out_mem[out_rp_reg][8])
						tx_st_reg <= rmh_pkg::RMH_TX_LF;
				end
				rmh_pkg::RMH_TX_LF:
				begin
					tx_valid_reg <= 1'b1;
					tx_data_reg <= `RMH_BYTE_LF; // RULE24
					tx_end_reg <= (mode == rmh_pkg::RMH_LINK_BUS); // RULE24
					tx_st_reg <= rmh_pkg::RMH_TX_DATA;
				end
				default:
					tx_st_reg <= rmh_pkg::RMH_TX_DATA;
			endcase
		end
	end
	assign tx_valid = tx_valid_reg;
	assign tx_data = tx_data_reg;
	assign tx_end = tx_end_reg;

	// ----------------------------------------
	// operation complete, trigger, clear pulses
	// ----------------------------------------
	logic opc_pend_reg;
	logic opc_set;
	logic meas_start_reg;
	logic data_ready_reg;
	logic abort_reg;
	assign opc_set = opc_pend_reg & ~ops_busy;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			opc_pend_reg <= 1'b0;
			opc_q_reg <= 1'b0;
		end
		else if (dcl)
		begin
			opc_pend_reg <= 1'b0; // RULE18
			opc_q_reg <= 1'b0;
		end
		else
		begin
			if (opc_cmd)
				opc_pend_reg <= 1'b1;
			else if (opc_set)
				opc_pend_reg <= 1'b0; // RULE21
			if (opc_query)
				opc_q_reg <= 1'b1;
			else if (opc_q_fire)
				opc_q_reg <= 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meas_start_reg <= 1'b0;
			data_ready_reg <= 1'b0;
			abort_reg <= 1'b0;
		end
		else
		begin
			abort_reg <= dcl; // RULE18
			meas_start_reg <= (trg_cmd | (ifmsg.get & (mode != rmh_pkg::RMH_LINK_SER)))
				& ctrl_reg[`RMH_CTRL_TRGBUS_BIT] & trig_waiting; // RULE20 RULE22
			if (meas_done)
				data_ready_reg <= 1'b1; // RULE22
			else if (meas_start_reg || dcl)
				data_ready_reg <= 1'b0;
		end
	end
	assign meas_start = meas_start_reg;
	assign data_ready = data_ready_reg;
	assign parse_abort = abort_reg;
	assign wait_release = abort_reg; // RULE18

	// ----------------------------------------
	// error queue
	// ----------------------------------------
	logic [7:0] err_mem [`RMH_ERR_DEPTH];
	logic [3:0] err_rp_reg;
	logic [4:0] err_cnt_reg;
	logic err_push;
	logic err_pop;
	logic [3:0] err_wp;
	logic apb_rd_done;
	assign err_wp = 4'(err_rp_reg + err_cnt_reg[3:0]);
	assign err_push = exe_error & (err_cnt_reg != 5'(`RMH_ERR_DEPTH)); // RULE6
	assign err_pop = apb_rd_done & (paddr == `RMH_OFS_ERRQ) & (err_cnt_reg != 5'h00);
	always_ff @(posedge pclk)
	begin
		if (err_push)
			err_mem[err_wp] <= (err_cnt_reg == 5'(`RMH_ERR_DEPTH - 1) && !err_pop) ? `RMH_ERR_QOVF
				: exe_error_code; // RULE7
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			err_rp_reg <= 4'h0;
			err_cnt_reg <= 5'h00;
		end
		else
		begin
			if (err_pop)
				err_rp_reg <= err_rp_reg + 4'h1;
			err_cnt_reg <= err_cnt_reg + 5'(err_push) - 5'(err_pop); // RULE6 RULE7
		end
	end

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	logic apb_wr_done;
	logic [7:0] esr_clr;
	assign apb_rd_done = psel & penable & ~pwrite;
	assign apb_wr_done = psel & penable & pwrite;
	assign esr_clr = (apb_wr_done && paddr == `RMH_OFS_ESR) ? pwdata[7:0] : 8'h00;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg <= `RMH_CTRL_RST;
			esr_reg <= `RMH_ESR_RST;
		end
		else
		begin
			if (apb_wr_done && paddr == `RMH_OFS_CTRL)
				ctrl_reg <= pwdata[2:0];
			esr_reg <= (esr_reg & ~esr_clr)
				| (8'(opc_set) << `RMH_ESR_OPC_BIT) // RULE21
				| (8'(out_ovf) << `RMH_ESR_QYE_BIT); // RULE4
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end
		else if (psel && !penable)
		begin
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			if (paddr == `RMH_OFS_CTRL)
				prdata_reg <= {29'h0, ctrl_reg};
			else if (paddr == `RMH_OFS_STAT)
				prdata_reg <= {16'h0, 3'h0, err_cnt_reg, data_ready_reg, drop_reg,
					skip_reg, talk_reg, lstn_reg, stb_mav[`RMH_STB_MAV_BIT], llo_reg, remote_reg};
			else if (paddr == `RMH_OFS_ESR)
				prdata_reg <= {24'h0, esr_reg};
			else if (paddr == `RMH_OFS_ERRQ)
			begin
				if (err_cnt_reg != 5'h00)
					prdata_reg <= {23'h0, 1'b1, err_mem[err_rp_reg]};
			end
			else
				pslverr_reg <= 1'b1;
		end
	end
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg & psel & penable;
	assign pready = 1'b1;
endmodule : rmh_handler

// ==== dv/rmh_handler_props.sv ====
`timescale 1ns/1ps
module rmh_handler_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_ready,
	input wire logic trg_cmd,
	input wire logic trig_waiting,
	input wire logic meas_start,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_end,
	input wire rmh_pkg::rmh_ifmsg_t ifmsg,
	input wire logic panel_key,
	input wire logic panel_local_key,
	input wire logic panel_key_pass,
	input wire logic remote_lamp,
	input wire logic listener,
	input wire logic talker,
	input wire logic ifc_reinit,
	input wire logic parse_abort,
	input wire logic wait_release,
	input wire logic [7:0] stb_mav
);
	// ---
	// shadow of the link mode and trigger source
	// ---
	logic [2:0] ctrl_reg;
	logic ser;
	assign ser = ctrl_reg[1:0] == 2'b10;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ctrl_reg <= 3'h0;
		else if (psel && penable && pwrite && pready && paddr == 12'h000)
			ctrl_reg <= pwdata[2:0];
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_CMD_HOLD:
	assert property (cmd_valid && !cmd_ready && !ifmsg.dcl && !ifmsg.ifc |=> cmd_valid && $stable(cmd_data))
		else $error("cmd byte not held");
	AST_TX_LF:
	assert property (tx_valid && tx_end |-> tx_data == 8'h0A)
		else $error("end without line feed");
	AST_PASS:
	assert property ($past(presetn, 2) |-> panel_key_pass == ($past(panel_key, 2) && !remote_lamp))
		else $error("panel key pass wrong");
	AST_REMOTE:
	assert property (ifmsg.ren && listener && !ser && !ifmsg.gtl && !ifmsg.usb_detach
		&& !$past(panel_local_key, 2) |=> remote_lamp)
		else $error("remote not entered");
	AST_LOCAL:
	assert property ((ifmsg.gtl || $fell(ifmsg.ren)) && !ser |=> !remote_lamp)
		else $error("local not entered");
	AST_MEAS_ON:
	assert property ((trg_cmd || ifmsg.get && !ser) && ctrl_reg[2] && trig_waiting |=> meas_start)
		else $error("trigger lost");
	AST_MEAS_ONLY:
	assert property (meas_start |-> $past((trg_cmd || ifmsg.get && !ser) && ctrl_reg[2] && trig_waiting))
		else $error("spurious measurement");
	AST_DCL:
	assert property (ifmsg.dcl && !ser |=> parse_abort && wait_release && !stb_mav[4])
		else $error("device clear incomplete");
	AST_IFC:
	assert property (ifmsg.ifc |=> ifc_reinit && !listener && !talker)
		else $error("interface clear incomplete");
endmodule : rmh_handler_props
bind rmh_handler rmh_handler_props rmh_handler_props_i (.*);

// ==== dv/rmh_host_model.sv ====
`timescale 1ns/1ps
module rmh_host_model (
	input wire logic pclk,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_end,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_end,
	output logic tx_ready
);
	logic stall = 1'b0;
	logic [8:0] got[$];
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_end = 1'b0;
		tx_ready = 1'b0;
	end
	// ---
	// reads responses at a random pace unless stalled
	// ---
	always @(posedge pclk)
	begin
		if (tx_valid && tx_ready)
			got.push_back({tx_end, tx_data});
		tx_ready <= !stall && $urandom_range(2) != 0;
	end
	task automatic send(input logic [7:0] m[$], input logic ser);
		m.push_back(8'h0A);
		foreach (m[i])
		begin
			rx_valid <= 1'b1;
			rx_data <= m[i];
			rx_end <= !ser && i == m.size() - 1;
			@(posedge pclk);
			while (!rx_ready)
				@(posedge pclk);
		end
		rx_valid <= 1'b0;
		rx_data <= 8'hF5;
		rx_end <= 1'b0;
	endtask : send
endmodule : rmh_host_model

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`include "rmh_defs.svh"
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, se;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = '0, prdata, q;
	logic pready, pslverr, rx_valid, rx_end, rx_ready, cmd_valid, cmd_term, tx_valid, tx_end, tx_ready;
	logic [7:0] rx_data, cmd_data, tx_data, stb_mav;
	logic cmd_ready = 1'b0, exe_error = 1'b0, opc_cmd = 1'b0, opc_query = 1'b0, trg_cmd = 1'b0;
	logic ops_busy = 1'b0, trig_waiting = 1'b0, meas_done = 1'b0, panel_key = 1'b0, panel_local_key = 1'b0;
	logic [7:0] exe_error_code = 8'h00;
	rmh_pkg::rmh_resp_t resp = '0;
	rmh_pkg::rmh_ifmsg_t ifmsg = '0;
	logic meas_start, data_ready, panel_key_pass, remote_lamp, listener, talker, ifc_reinit, parse_abort;
	logic wait_release;
	logic [8:0] cq[$], ex[$];
	logic [7:0] body[$], codes[$];
	int fails = 0;
	int n_checks = 0;
	always #10 pclk = ~pclk;
	rmh_handler rmh_handler_i (.*);
	rmh_host_model rmh_host_model_i (.*);
	always @(posedge pclk)
	begin
		if (cmd_valid && cmd_ready)
			cq.push_back({cmd_term, cmd_data});
		cmd_ready <= 1'($urandom_range(1));
		panel_key <= 1'($urandom_range(1));
	end
	// ---
	// helpers
	// ---
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : cmp
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask : wt
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (!pready)
			@(posedge pclk);
		q = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic pm(input int b);
		ifmsg[b] <= 1'b1;
		@(posedge pclk);
		ifmsg[b] <= 1'b0;
		@(posedge pclk);
	endtask : pm
	task automatic key;
		panel_local_key <= 1'b1;
		wt(5);
		panel_local_key <= 1'b0;
		wt(5);
	endtask : key
	task automatic err(input logic [7:0] c);
		exe_error <= 1'b1;
		exe_error_code <= c;
		@(posedge pclk);
		exe_error <= 1'b0;
		@(posedge pclk);
	endtask : err
	task automatic push(input logic [7:0] r[$]);
		foreach (r[i])
		begin
			resp <= {1'b1, r[i], i == r.size() - 1};
			@(posedge pclk);
		end
		resp <= '0;
		@(posedge pclk);
	endtask : push
	task automatic drain(input int n);
		for (int k = 0; k < 5000 && cq.size() < n; k++)
			@(posedge pclk);
	endtask : drain
	function automatic logic [8:0] cmd_exp(input logic [7:0] b);
		return {b == `RMH_BYTE_LF, b};
	endfunction : cmd_exp
	function automatic logic [31:0] errq_exp(input int i);
		if (i > 15)
			return '0;
		return {23'h0, 1'b1, i < 15 ? codes[i] : `RMH_ERR_QOVF};
	endfunction : errq_exp
	// ---
	// tests
	// ---
	initial
	begin
		repeat (90000) @(posedge pclk);
		fails++;
		complete_run();
	end
	initial
	begin
		void'($urandom(78));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, 12'h008, '0);
		cmp("esr", '0, q);
		apb(0, 12'h004, '0);
		cmp("status", '0, q);
		apb(0, 12'h010, '0);
		cmp("unmapped", 32'h0000_0001, {q[30:0], se});
		repeat (1100)
			body.push_back(8'h20 + 8'($urandom_range(94)));
		rmh_host_model_i.send(body, 1'b0);
		drain(1101);
		foreach (body[i])
			cmp("cmd", cmd_exp(body[i]), cq[i]);
		cmp("term", cmd_exp(8'h0A), cq[1100]);
		cq.delete();
		codes = '{8'h41};
		err(8'h41);
		rmh_host_model_i.send('{8'h41, 8'h42}, 1'b0);
		drain(1);
		wt(10);
		cmp("skip count", 1, cq.size());
		cmp("skip term", cmd_exp(8'h0A), cq[0]);
		repeat (16)
		begin
			codes.push_back(8'h01 + 8'($urandom_range(200)));
			err(codes[$]);
		end
		apb(0, 12'h004, '0);
		cmp("err count", 16, q[12:8]);
		for (int i = 0; i < 17; i++)
		begin
			apb(0, 12'h00C, '0);
			cmp("errq", errq_exp(i), q);
		end
		body = '{};
		repeat (4)
			body.push_back(8'($urandom));
		rmh_host_model_i.got.delete();
		opc_query <= 1'b1;
		@(posedge pclk);
		opc_query <= 1'b0;
		@(posedge pclk);
		push(body);
		wt(40);
		ex = '{9'h031, 9'h10A};
		foreach (body[i])
			ex.push_back({1'b0, body[i]});
		ex.push_back(9'h10A);
		cmp("tx count", ex.size(), rmh_host_model_i.got.size());
		foreach (ex[i])
			cmp("tx", ex[i], rmh_host_model_i.got[i]);
		ops_busy <= 1'b1;
		opc_cmd <= 1'b1;
		@(posedge pclk);
		opc_cmd <= 1'b0;
		wt(5);
		apb(0, 12'h008, '0);
		cmp("esr busy", '0, q);
		ops_busy <= 1'b0;
		wt(3);
		apb(0, 12'h008, '0);
		cmp("esr opc", 32'h0000_0001, q);
		apb(1, 12'h008, 32'h0000_0001);
		rmh_host_model_i.stall = 1'b1;
		resp <= '{1'b1, 8'h55, 1'b0};
		wt(65540);
		resp <= '0;
		apb(0, 12'h008, '0);
		cmp("esr ovf", 32'h0000_0004, q);
		rmh_host_model_i.stall = 1'b0;
		wt(20);
		rmh_host_model_i.got.delete();
		push('{8'h61, 8'h62});
		wt(20);
		cmp("dropped", '0, rmh_host_model_i.got.size());
		rmh_host_model_i.send('{8'h58}, 1'b0);
		wt(20);
		push('{8'h63});
		wt(20);
		cmp("resumed", 2, rmh_host_model_i.got.size());
		rmh_host_model_i.stall = 1'b1;
		push('{8'h64});
		wt(3);
		cmp("mav", 32'h0000_0010, stb_mav);
		pm(4);
		cmp("mav dcl", '0, stb_mav);
		rmh_host_model_i.stall = 1'b0;
		rmh_host_model_i.got.delete();
		wt(20);
		cmp("tx dcl", '0, rmh_host_model_i.got.size());
		ifmsg.ren <= 1'b1;
		pm(9);
		wt(3);
		cmp("remote", 1, remote_lamp);
		pm(8);
		pm(3);
		key();
		cmp("locked", 1, remote_lamp);
		pm(2);
		wt(2);
		cmp("gtl", '0, remote_lamp);
		ifmsg.ren <= 1'b0;
		wt(2);
		ifmsg.ren <= 1'b1;
		pm(9);
		pm(8);
		wt(2);
		key();
		cmp("key", '0, remote_lamp);
		pm(9);
		pm(7);
		cmp("talk", 1, talker);
		pm(5);
		wt(2);
		cmp("ifc", '0, listener);
		cmp("ifc talk", '0, talker);
		ifmsg.ren <= 1'b0;
		wt(3);
		cmp("ren low", '0, remote_lamp);
		apb(1, 12'h000, 32'h0000_0001);
		ifmsg.ren <= 1'b1;
		pm(9);
		pm(8);
		wt(2);
		cmp("usb remote", 1, remote_lamp);
		pm(0);
		wt(2);
		cmp("detach", '0, remote_lamp);
		ifmsg.ren <= 1'b0;
		apb(1, 12'h000, 32'h0000_0002);
		cq.delete();
		rmh_host_model_i.send('{8'h52}, 1'b1);
		drain(2);
		cmp("serial term", cmd_exp(8'h0A), cq[1]);
		cmp("serial remote", 1, remote_lamp);
		pm(2);
		wt(2);
		cmp("serial gtl", 1, remote_lamp);
		key();
		cmp("serial key", '0, remote_lamp);
		apb(1, 12'h000, 32'h0000_0004);
		for (int i = 0; i < 80; i++)
		begin
			if (i == 40)
				apb(1, 12'h000, '0);
			trg_cmd <= 1'($urandom_range(1));
			ifmsg.get <= 1'($urandom_range(1));
			trig_waiting <= 1'($urandom_range(1));
			@(posedge pclk);
		end
		trg_cmd <= 1'b0;
		ifmsg.get <= 1'b0;
		meas_done <= 1'b1;
		@(posedge pclk);
		meas_done <= 1'b0;
		wt(2);
		cmp("data ready", 1, data_ready);
		complete_run();
	end
endmodule : testbench
